// ### hdl/emo_ext_match.sv
// External match output control with APB register access
//
// Functional notes
// - Match on value 0 updates state bit 0 per action field 5:4.
// - Match on value 1 updates state bit 1 per action field 7:6.
// - Match on value 2 updates state bit 2 per action field 9:8.
// - Match on value 3 updates state bit 3 per action field 11:10.
// - State bits always readable, whether or not pinned out.
// - Pin selected for match function is driven by its state bit, or by PWM when its channel is in PWM mode.
// - Action 00 hold, 01 clear, 10 set, 11 toggle.
// - Reset clears all state bits and action fields.
// - Each match value compared continuously with the timer count.
// - Channel in PWM mode follows PWM rules, not the action field.
module emo_ext_match
#(
   parameter int CNT_W = 32
)
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              clk_en,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [CNT_W-1:0]  timer_count,
   input  wire logic [3:0]        pwm_out,
   output logic      [3:0]        match_out_pin
);
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [CNT_W-1:0] match_value_ff [emo_pkg::NUM_CH];
   logic [CNT_W-1:0] nxt_match_value [emo_pkg::NUM_CH];
   logic [3:0]       out_state_ff;
   logic [3:0]       nxt_out_state;
   logic [7:0]       match_action_ff;
   logic [7:0]       nxt_match_action;
   logic [3:0]       pwm_en_ff;
   logic [3:0]       nxt_pwm_en;
   logic [3:0]       pin_config_ff;
   logic [3:0]       nxt_pin_config;
   logic [3:0]       eq_prev_ff;
   logic [3:0]       match_eq;
   logic [3:0]       match_evt;
   logic [31:0]      nxt_prdata;
   logic             wr_acc;
   logic             rd_acc;
   logic             addr_ok;

   function automatic logic apply_action(input logic cur, input logic [1:0] act);
      logic r;
      r = cur;
      unique case (act)
         emo_pkg::EMO_ACT_NONE:   r = cur;
         emo_pkg::EMO_ACT_CLEAR:  r = 1'b0;
         emo_pkg::EMO_ACT_SET:    r = 1'b1;
         emo_pkg::EMO_ACT_TOGGLE: r = ~cur;
      endcase
      return r;
   endfunction

   function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
      return a == ofs;
   endfunction

   // ------------------------------------------------------------
   // Match detect
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < emo_pkg::NUM_CH; g++)
      begin : g_cmp
         assign match_eq[g] = (timer_count == match_value_ff[g]);
         assign match_evt[g] = match_eq[g] & ~eq_prev_ff[g];
      end
   endgenerate

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   // Read data latched at setup, so no wait state is ever needed
   assign pready = 1'b1;
   assign wr_acc = psel & penable & pwrite & clk_en;
   assign rd_acc = psel & ~penable & ~pwrite;
   // Unmapped addresses answer with an error, no side effect
   assign pslverr = psel & penable & ~addr_ok;

   always_comb
   begin
      addr_ok = addr_is(paddr, emo_pkg::EXT_MATCH_REG_OFS) |
                addr_is(paddr, emo_pkg::PWM_CTRL_OFS) |
                addr_is(paddr, emo_pkg::PIN_CONFIG_OFS) |
                addr_is(paddr, emo_pkg::TIMER_COUNT_OFS);
      for (int i = 0; i < emo_pkg::NUM_CH; i++)
      begin
         if (addr_is(paddr, emo_pkg::MATCH_VALUE0_OFS + 12'(4 * i)))
         begin
            addr_ok = 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      nxt_out_state    = out_state_ff;
      nxt_match_action = match_action_ff;
      nxt_pwm_en       = pwm_en_ff;
      nxt_pin_config   = pin_config_ff;
      nxt_match_value  = match_value_ff;
      // software write first; a same-cycle match acts on written value
      if (wr_acc && addr_is(paddr, emo_pkg::EXT_MATCH_REG_OFS))
      begin
         nxt_out_state    = pwdata[emo_pkg::STATE_LSB +: 4];
         nxt_match_action = pwdata[emo_pkg::ACTION_LSB +: 8];
      end
      if (wr_acc && addr_is(paddr, emo_pkg::PWM_CTRL_OFS))
      begin
         nxt_pwm_en = pwdata[3:0];
      end
      if (wr_acc && addr_is(paddr, emo_pkg::PIN_CONFIG_OFS))
      begin
         nxt_pin_config = pwdata[3:0];
      end
      for (int i = 0; i < emo_pkg::NUM_CH; i++)
      begin
         if (wr_acc && addr_is(paddr, emo_pkg::MATCH_VALUE0_OFS + 12'(4 * i)))
         begin
            nxt_match_value[i] = pwdata[CNT_W-1:0];
         end
         if (match_evt[i] && !pwm_en_ff[i])
         begin
            nxt_out_state[i] = apply_action(nxt_out_state[i], nxt_match_action[2*i +: 2]);
         end
      end
   end

   always_comb
   begin
      nxt_prdata = prdata;
      if (rd_acc)
      begin
         nxt_prdata = '0;
         // state readable regardless of pin routing
         if (addr_is(paddr, emo_pkg::EXT_MATCH_REG_OFS))
         begin
            nxt_prdata[emo_pkg::EMR_USED_W-1:0] = {match_action_ff, out_state_ff};
         end
         if (addr_is(paddr, emo_pkg::PWM_CTRL_OFS))
         begin
            nxt_prdata[3:0] = pwm_en_ff;
         end
         if (addr_is(paddr, emo_pkg::PIN_CONFIG_OFS))
         begin
            nxt_prdata[3:0] = pin_config_ff;
         end
         if (addr_is(paddr, emo_pkg::TIMER_COUNT_OFS))
         begin
            nxt_prdata[CNT_W-1:0] = timer_count;
         end
         for (int i = 0; i < emo_pkg::NUM_CH; i++)
         begin
            if (addr_is(paddr, emo_pkg::MATCH_VALUE0_OFS + 12'(4 * i)))
            begin
               nxt_prdata[CNT_W-1:0] = match_value_ff[i];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // reset values
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         out_state_ff    <= 4'h0;
         match_action_ff <= 8'h00;
         pwm_en_ff       <= 4'h0;
         pin_config_ff   <= 4'h0;
         // History starts high: a count already equal at reset is no event
         eq_prev_ff      <= 4'hF;
         prdata          <= 32'h0000_0000;
         for (int i = 0; i < emo_pkg::NUM_CH; i++)
         begin
            match_value_ff[i] <= CNT_W'(emo_pkg::MATCH_RESET);
         end
      end
      else if (clk_en)
      begin
         out_state_ff    <= nxt_out_state;
         match_action_ff <= nxt_match_action;
         pwm_en_ff       <= nxt_pwm_en;
         pin_config_ff   <= nxt_pin_config;
         eq_prev_ff      <= match_eq;
         prdata          <= nxt_prdata;
         match_value_ff  <= nxt_match_value;
      end
   end

   // ------------------------------------------------------------
   // Pin output
   // ------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < emo_pkg::NUM_CH; i++)
      begin
         // Unselected pin is driven low, never floated
         // pin from state bit, or from PWM in PWM mode
         match_out_pin[i] = pin_config_ff[i] & (pwm_en_ff[i] ? pwm_out[i] : out_state_ff[i]);
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic ext_wr;
   assign ext_wr = wr_acc && addr_is(paddr, emo_pkg::EXT_MATCH_REG_OFS);

   AST_CLEAR0: assert property (clk_en && match_evt[0] && !pwm_en_ff[0] && !ext_wr &&
      match_action_ff[1:0] == 2'b01 |=> !out_state_ff[0])
      else $error("clear action on channel 0 missed");
   AST_SET1: assert property (clk_en && match_evt[1] && !pwm_en_ff[1] && !ext_wr &&
      match_action_ff[3:2] == 2'b10 |=> out_state_ff[1])
      else $error("set action on channel 1 missed");
   AST_TOG2: assert property (clk_en && match_evt[2] && !pwm_en_ff[2] && !ext_wr &&
      match_action_ff[5:4] == 2'b11 |=> out_state_ff[2] != $past(out_state_ff[2]))
      else $error("toggle action on channel 2 missed");
   AST_TOG3: assert property (clk_en && match_evt[3] && !pwm_en_ff[3] && !ext_wr &&
      match_action_ff[7:6] == 2'b11 |=> out_state_ff[3] != $past(out_state_ff[3]))
      else $error("toggle action on channel 3 missed");
   AST_HOLD: assert property (clk_en && !ext_wr && match_evt == 4'h0
      |=> out_state_ff == $past(out_state_ff))
      else $error("state changed without match or write");
   AST_PIN: assert property (pin_config_ff[0] && !pwm_en_ff[0]
      |-> match_out_pin[0] == out_state_ff[0])
      else $error("pin does not follow state bit");
   AST_PINOFF: assert property (!pin_config_ff[1] |-> !match_out_pin[1])
      else $error("pin driven while not selected");
   AST_RD: assert property (rd_acc && clk_en &&
      addr_is(paddr, emo_pkg::EXT_MATCH_REG_OFS) |=> prdata[3:0] == $past(out_state_ff))
      else $error("read of state bits wrong");
   AST_WR: assert property (ext_wr && match_evt == 4'h0
      |=> out_state_ff == $past(pwdata[3:0]))
      else $error("software write not stored");
   AST_PWM: assert property (clk_en && !ext_wr |=>
      (out_state_ff & $past(pwm_en_ff)) == ($past(out_state_ff) & $past(pwm_en_ff)))
      else $error("action applied in PWM mode");

   generate
      for (g = 0; g < emo_pkg::NUM_CH; g++)
      begin : g_ast
         AST_DECODE: assert property (clk_en && match_evt[g] && !pwm_en_ff[g] &&
            !ext_wr |=> out_state_ff[g] == ($past(match_action_ff[2*g+1]) ?
               ($past(match_action_ff[2*g]) ? !$past(out_state_ff[g]) : 1'b1) :
               ($past(match_action_ff[2*g]) ? 1'b0 : $past(out_state_ff[g]))))
            else $error("match action decoded wrongly");
         AST_ONCE: assert property (clk_en && match_eq[g] && eq_prev_ff[g] && !ext_wr
            |=> out_state_ff[g] == $past(out_state_ff[g]))
            else $error("action repeated while equality held");
         AST_PINLOW: assert property (!pin_config_ff[g] |-> !match_out_pin[g])
            else $error("pin driven without match function");
         AST_PINPWM: assert property (pin_config_ff[g] && pwm_en_ff[g] |->
            match_out_pin[g] == pwm_out[g])
            else $error("pin does not follow PWM level");
      end
   endgenerate

   // Main scenarios
   COV_TOG:  cover property (match_evt[2] && match_action_ff[5:4] == 2'b11);
   COV_WR:   cover property (ext_wr);
   COV_PIN:  cover property (pin_config_ff[3] && match_out_pin[3]);
   COV_HELD: cover property (match_eq[2] && eq_prev_ff[2]);
   COV_PWM:  cover property (pwm_en_ff[2] && match_evt[2]);
endmodule

// ### hdl/emo_pkg.sv
// Package: register map, field layout and encodings of the external match block
package emo_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [11:0] EXT_MATCH_REG_OFS = 12'h03C;
   localparam logic [11:0] MATCH_VALUE0_OFS  = 12'h018;
   localparam logic [11:0] TIMER_COUNT_OFS   = 12'h008;
   localparam logic [11:0] PWM_CTRL_OFS      = 12'h074;
   localparam logic [11:0] PIN_CONFIG_OFS    = 12'h080;
   // ------------------------------------------------------------
   // Field layout
   // ------------------------------------------------------------
   localparam int          NUM_CH            = 4;
   localparam int          STATE_LSB         = 0;
   localparam int          ACTION_LSB        = 4;
   localparam int          ACTION_W          = 2;
   localparam int          EMR_USED_W        = 12;
   localparam logic [31:0] EMR_RESET         = 32'h0000_0000;
   localparam logic [31:0] MATCH_RESET       = 32'h0000_0000;
   typedef enum logic [1:0]
   {
      EMO_ACT_NONE   = 2'b00,
      EMO_ACT_CLEAR  = 2'b01,
      EMO_ACT_SET    = 2'b10,
      EMO_ACT_TOGGLE = 2'b11
   } emo_action_e;
endpackage

// ### sim/emo_pin_model.sv
// Board-side model of the match output pins
module emo_pin_model
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [3:0] pin,
   output logic      [3:0] level_ff
);
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------------------------------------
   // Pin sampling
   // ------------------------------------------------------------
   // Level is seen one edge late, as a board receiver would
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         level_ff <= 4'h0;
      else
         level_ff <= pin;
   end
endmodule

// ### sim/emo_ext_match_test.sv
// Self-checking bench of the external match block
module emo_ext_match_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, err;
   logic [31:0] timer_count = 32'hFFFF_FFFF;
   logic [3:0] pwm_out = 4'h0, match_out_pin, level;
   int mismatches = 0, samples_checked = 0;
   always #2 pclk = ~pclk;
   emo_ext_match uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_count(timer_count),
      .pwm_out(pwm_out), .match_out_pin(match_out_pin));
   emo_pin_model pins (.pclk(pclk), .presetn(presetn), .pin(match_out_pin),
      .level_ff(level));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Wait for the slave; only the watchdog ends a hung wait
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   // Count sits on the value for len cycles, then moves off
   task automatic hit(input logic [31:0] v, input int len);
      @(posedge pclk);
      timer_count <= v;
      repeat (len) @(posedge pclk);
      timer_count <= 32'hFFFF_FFFF;
      repeat (2) @(posedge pclk);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_actions;
      for (int i = 0; i < 4; i++)
         apb(1'b1, 12'h018 + 12'(4 * i), 32'h10 * (i + 1));
      apb(1'b1, 12'h080, 32'hF);
      apb(1'b1, 12'h03C, 32'h36A);
      hit(32'h10, 1);
      rd_chk(12'h03C, 32'h36B); // set
      hit(32'h20, 1);
      rd_chk(12'h03C, 32'h369); // clear
      hit(32'h30, 5);
      rd_chk(12'h03C, 32'h36D); // toggle once
      hit(32'h40, 1);
      rd_chk(12'h03C, 32'h36D); // no action
      chk(32'(match_out_pin), 32'hD); // pin level
      chk(32'(level), 32'hD); // seen at the board
   endtask
   task automatic t_sw_write;
      apb(1'b1, 12'h03C, 32'h304);
      hit(32'h30, 1);
      rd_chk(12'h03C, 32'h300); // starts from written one
      apb(1'b1, 12'h03C, 32'h300);
      hit(32'h30, 1);
      rd_chk(12'h03C, 32'h304); // starts from written zero
   endtask
   task automatic t_unpinned;
      apb(1'b1, 12'h080, 32'h0);
      // Pin select lands on the last edge of the write
      @(posedge pclk);
      chk(32'(match_out_pin), 32'h0); // not selected
      hit(32'h30, 1);
      rd_chk(12'h03C, 32'h300); // toggled without pin
   endtask
   task automatic t_pwm;
      apb(1'b1, 12'h080, 32'hF);
      apb(1'b1, 12'h074, 32'h4);
      pwm_out <= 4'h4;
      hit(32'h30, 1);
      chk(32'(match_out_pin), 32'h4); // pin from pwm
      rd_chk(12'h03C, 32'h300); // action ignored
      pwm_out <= 4'h0;
      @(posedge pclk);
      chk(32'(match_out_pin), 32'h0); // pin from pwm
   endtask
   task automatic t_more;
      apb(1'b1, 12'h03C, 32'hC91);
      hit(32'h10, 1);
      rd_chk(12'h03C, 32'hC90); // clear
      hit(32'h20, 1);
      rd_chk(12'h03C, 32'hC92); // set
      hit(32'h40, 1);
      rd_chk(12'h03C, 32'hC9A); // toggle
      chk(32'(match_out_pin), 32'hA); // pins 0, 1, 3 follow state; pin 2 from pwm
      // Frozen clock enable drops the write
      clk_en <= 1'b0;
      apb(1'b1, 12'h03C, 32'h000);
      clk_en <= 1'b1;
      rd_chk(12'h03C, 32'hC9A); // write lost while frozen
   endtask
   task automatic t_reset;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk(32'(match_out_pin), 32'h0); // pins low after reset
      rd_chk(12'h03C, 32'h0); // state and actions cleared
      rd_chk(12'h018, 32'h0); // match value cleared
      rd_chk(12'h074, 32'h0); // PWM enable cleared
   endtask
   task automatic t_unmapped;
      apb(1'b0, 12'h100, 32'h0);
      chk({q[30:0], err}, 32'h1); // no register there
   endtask
   // ------------------------------------------------------------
   // Run control
   // ------------------------------------------------------------
   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      #40000;
      mismatches++;
      results();
   end
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(12'h03C, 32'h0); // reset value
      chk(32'(match_out_pin), 32'h0); // pins low
      t_actions();
      t_sw_write();
      t_unpinned();
      t_pwm();
      t_more();
      t_reset();
      t_unmapped();
      results();
   end
endmodule
